// file: verilog/mic_pkg.sv
// shared constants and carrier types for the interrupt controller
package mic_pkg;
	// ==========================================================
	// bus geometry and register byte offsets
	localparam int         ADDR_W      = 5;
	localparam int         DATA_W      = 32;
	localparam logic [4:0] REG_ENABLE  = 5'h00;
	localparam logic [4:0] REG_FLAGS   = 5'h04;
	localparam logic [4:0] REG_EDGE    = 5'h08;
	localparam logic [4:0] REG_SRCFLAG = 5'h0c;
	localparam logic [4:0] REG_TB0     = 5'h10;
	localparam logic [4:0] REG_TB1     = 5'h14;
	localparam logic [4:0] REG_STATUS  = 5'h18;

	// ==========================================================
	// request indices, in priority order (lowest index served first)
	localparam int NUM_IRQ   = 10;
	localparam int NUM_EXT   = 3;
	localparam int NUM_GRP   = 3;
	localparam int NUM_SRC   = 10;
	localparam int IDX_EXT0  = 0;
	localparam int IDX_CMP   = 3;
	localparam int IDX_GRP0  = 4;
	localparam int IDX_CONV  = 7;
	localparam int IDX_TICK0 = 8;
	localparam int IDX_TICK1 = 9;
	localparam int IDX_W     = 4;

	// enable register: global enable at bit 0, per-request enables above it
	localparam int EN_GIE    = 0;
	localparam int EN_BASE   = 1;

	// group source flags: timer events 0..3, timer events 4..7, low voltage, eeprom
	localparam logic [9:0] GRP_MASK [NUM_GRP] = '{10'h00f, 10'h0f0, 10'h300};

	// ==========================================================
	// edge selection per external pin
	localparam int         EDGE_W    = 2;
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// ==========================================================
	// time base control: period [2:0], enable bit 7, source [9:8]
	localparam int         TB_PER_LSB = 0;
	localparam int         TB_ON_BIT  = 7;
	localparam int         TB_SRC_LSB = 8;
	localparam logic [1:0] CLK_SYS    = 2'h0;
	localparam logic [1:0] CLK_DIV4   = 2'h1;
	localparam int         PRE_DIV    = 4;
	localparam int         TB_MIN_EXP = 8;
	localparam int         TB_CNT_W   = 15;

	// ==========================================================
	// status register bits and vector table
	localparam int          ST_STACK   = 0;
	localparam int          ST_PEND    = 1;
	localparam int          ST_GIE     = 2;
	localparam int          ST_LAST    = 4;
	localparam int          PC_W       = 12;
	localparam logic [11:0] VEC_BASE   = 12'h004;
	localparam logic [11:0] VEC_STEP   = 12'h004;

	typedef struct packed {
		logic       on;
		logic [1:0] src;
		logic [2:0] period;
	} mic_tb_s;

	typedef struct packed {
		logic            push;
		logic [PC_W-1:0] pushData;
		logic [PC_W-1:0] fetchAddr;
	} mic_call_s;
endpackage

// file: verilog/mic_time_base.sv
// time base: clock source select, /4 prescale and power-of-two overflow divider
`timescale 1ns/10ps
module mic_time_base #(
	parameter int CNT_W = mic_pkg::TB_CNT_W
) (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// control and sub clock enable
	input  wire mic_pkg::mic_tb_s ctrl,
	input  wire logic            subTick,
	// overflow event
	output logic                 tick
);
	// ==========================================================
	// prescaler source
	logic [1:0]       div4_r;
	logic [CNT_W-1:0] cnt_r;
	logic             preEn;
	logic [CNT_W-1:0] lowMask;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			div4_r <= 2'h0;
		else
			div4_r <= div4_r + 2'h1;
	end

	always_comb begin
		if (ctrl.src[1])
			preEn = subTick; // R21 R19
		else if (ctrl.src == mic_pkg::CLK_DIV4)
			preEn = (div4_r == 2'(mic_pkg::PRE_DIV - 1)); // R19
		else
			preEn = 1'b1;
	end

	// ==========================================================
	// divider: overflow every 2^(8+period) prescaled clocks
	assign lowMask = CNT_W'((32'h1 << (mic_pkg::TB_MIN_EXP + int'(ctrl.period))) - 32'h1); // R22

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_r <= '0;
		else if (!ctrl.on)
			cnt_r <= '0;
		else if (preEn)
			cnt_r <= cnt_r + CNT_W'(1);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tick <= 1'b0;
		else
			tick <= ctrl.on && preEn && ((cnt_r & lowMask) == lowMask); // R18
	end
endmodule // mic_time_base

// file: verilog/mic_intc.sv
// interrupt controller top: flags, enables, priority, call sequencing, registers
// ==========================================================
// Summary of operation
// [R1] taking any interrupt clears the global enable
// [R2] requests still latch flags while the global enable is clear
// [R3] software sets the global enable inside a handler to allow nesting
// [R4] no acknowledge while the return stack is full
// [R5] simultaneous requests served lowest vector first
// [R6] any flag rising wakes from sleep or idle; preset flags suppress this
// [R7] external flag set on the edge chosen for its pin
// [R8] external request needs global enable, pin enable and a live edge select
// [R9] software routes the shared pin as an input with its enable set
// [R10] servicing an external request clears its flag
// [R11] edge select offers rising, falling, both or disabled
// [R12] comparator flag set on every comparator output change
// [R13] comparator request vectors when enabled, flag cleared on service
// [R14] three group flags, each set when any of its source flags sets
// [R15] servicing a group clears its group flag and global enable
// [R16] group service leaves source flags; software clears them
// [R17] conversion done sets its flag, vectors when enabled, auto-cleared
// [R18] each time base overflow sets its flag, vectors, auto-cleared
// [R19] time base clock from system, system/4 or sub clock, then divided
// [R20] edge select codes 00 off, 01 rise, 10 fall, 11 both
// [R21] clock select codes 00 system, 01 system/4, 1x sub clock
// [R22] period select gives 2^8 to 2^15 prescaled clocks, separate enable
// [R23] acknowledge pushes the program counter and loads the vector
`timescale 1ns/10ps
module mic_intc (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// avalon-mm slave
	input  wire logic [4:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	// event sources
	input  wire logic [2:0]           extIrqPins,
	input  wire logic                 cmpOut,
	input  wire logic                 convDone,
	input  wire logic [7:0]           timerEvt,
	input  wire logic                 lowVoltEvt,
	input  wire logic                 eepromEvt,
	input  wire logic                 subTick,
	// cpu core side
	input  wire logic                 cpuReady,
	input  wire logic                 stackFull,
	input  wire logic [11:0]          pcIn,
	output mic_pkg::mic_call_s        call,
	output logic                      irqPending,
	output logic                      wakeUp
);
	// ==========================================================
	// state
	logic                          globalIrqEnable_r;
	logic [mic_pkg::NUM_IRQ-1:0]   irqEnable_r;
	logic [mic_pkg::NUM_IRQ-1:0]   reqFlags_r;
	logic [mic_pkg::NUM_IRQ-1:0]   reqFlags_nxt;
	logic [mic_pkg::NUM_SRC-1:0]   srcFlags_r;
	logic [mic_pkg::NUM_SRC-1:0]   srcFlags_nxt;
	logic [5:0]                    edgeSelectReg_r;
	mic_pkg::mic_tb_s              tick0Control_r;
	mic_pkg::mic_tb_s              tick1Control_r;
	logic [2:0]                    pinPrev_r;
	logic                          cmpPrev_r;
	logic                          primed_r;
	logic                          busDone_r;
	logic [mic_pkg::IDX_W-1:0]     lastIdx_r;
	logic [mic_pkg::NUM_IRQ-1:0]   hwSet;
	logic [mic_pkg::NUM_IRQ-1:0]   pending;
	logic [mic_pkg::NUM_IRQ-1:0]   ackClr;
	logic [mic_pkg::NUM_SRC-1:0]   srcSet;
	logic [mic_pkg::IDX_W-1:0]     ackIdx;
	logic                          ackTake;
	logic                          wrEn;
	logic [31:0]                   laneMask;
	logic [mic_pkg::NUM_IRQ-1:0]   enLanes;
	logic [1:0]                    tickEvt;

	// ==========================================================
	// helpers
	function automatic logic [mic_pkg::IDX_W-1:0] lowestOne(input logic [9:0] v);
		logic [mic_pkg::IDX_W-1:0] idx;
		idx = '0;
		for (int i = mic_pkg::NUM_IRQ - 1; i >= 0; i--) begin
			if (v[i])
				idx = mic_pkg::IDX_W'(i);
		end
		return idx;
	endfunction

	function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
		logic hit;
		case (sel) // R20 R11
			mic_pkg::EDGE_RISE: hit = !prev && cur;
			mic_pkg::EDGE_FALL: hit = prev && !cur;
			mic_pkg::EDGE_BOTH: hit = prev != cur;
			default:            hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				res[b*8 +: 8] = wd[b*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic [9:0] tbPack(input mic_pkg::mic_tb_s t);
		logic [9:0] r;
		r = '0;
		r[mic_pkg::TB_PER_LSB +: 3] = t.period;
		r[mic_pkg::TB_ON_BIT] = t.on;
		r[mic_pkg::TB_SRC_LSB +: 2] = t.src;
		return r;
	endfunction

	function automatic mic_pkg::mic_tb_s tbUnpack(input logic [31:0] w);
		mic_pkg::mic_tb_s t;
		t.period = w[mic_pkg::TB_PER_LSB +: 3];
		t.on     = w[mic_pkg::TB_ON_BIT];
		t.src    = w[mic_pkg::TB_SRC_LSB +: 2];
		return t;
	endfunction

	// ==========================================================
	// bus slave: one wait state on every access
	assign avs_waitrequest = (avs_read || avs_write) && !busDone_r;
	assign wrEn            = avs_write && busDone_r;
	// byte lanes as a bit mask, so narrow registers merge without slicing a call
	assign laneMask        = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign enLanes         = laneMask[mic_pkg::EN_BASE +: mic_pkg::NUM_IRQ];

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			busDone_r <= 1'b0;
		else
			busDone_r <= (avs_read || avs_write) && !busDone_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !busDone_r) begin
			case (avs_address)
				mic_pkg::REG_ENABLE:  avs_readdata <= {21'h0, irqEnable_r, globalIrqEnable_r};
				mic_pkg::REG_FLAGS:   avs_readdata <= {22'h0, reqFlags_r};
				mic_pkg::REG_EDGE:    avs_readdata <= {26'h0, edgeSelectReg_r};
				mic_pkg::REG_SRCFLAG: avs_readdata <= {22'h0, srcFlags_r};
				mic_pkg::REG_TB0:     avs_readdata <= {22'h0, tbPack(tick0Control_r)};
				mic_pkg::REG_TB1:     avs_readdata <= {22'h0, tbPack(tick1Control_r)};
				mic_pkg::REG_STATUS:  avs_readdata <= {24'h0, lastIdx_r, 1'b0,
					globalIrqEnable_r, irqPending, stackFull};
				default:              avs_readdata <= 32'h0;
			endcase
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqEnable_r     <= '0;
			edgeSelectReg_r <= '0;
			tick0Control_r  <= '0;
			tick1Control_r  <= '0;
		end else if (wrEn) begin
			case (avs_address)
				mic_pkg::REG_ENABLE: irqEnable_r <= (irqEnable_r & ~enLanes) |
					(avs_writedata[mic_pkg::EN_BASE +: mic_pkg::NUM_IRQ] & enLanes);
				mic_pkg::REG_EDGE:   edgeSelectReg_r <= (edgeSelectReg_r & ~laneMask[5:0]) |
					(avs_writedata[5:0] & laneMask[5:0]);
				mic_pkg::REG_TB0:    tick0Control_r <= tbUnpack(beMerge({22'h0,
					tbPack(tick0Control_r)}, avs_writedata, avs_byteenable));
				mic_pkg::REG_TB1:    tick1Control_r <= tbUnpack(beMerge({22'h0,
					tbPack(tick1Control_r)}, avs_writedata, avs_byteenable));
				default: ;
			endcase
		end
	end

	// acknowledge wins over a software set in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			globalIrqEnable_r <= 1'b0;
		else if (ackTake)
			globalIrqEnable_r <= 1'b0; // R1
		else if (wrEn && avs_address == mic_pkg::REG_ENABLE && avs_byteenable[0])
			globalIrqEnable_r <= avs_writedata[mic_pkg::EN_GIE];
	end

	// ==========================================================
	// event detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinPrev_r <= '0;
			cmpPrev_r <= 1'b0;
			primed_r  <= 1'b0;
		end else begin
			pinPrev_r <= extIrqPins;
			cmpPrev_r <= cmpOut;
			primed_r  <= 1'b1;
		end
	end

	// primed_r masks the first sample so reset levels are not seen as edges
	generate
		for (genvar p = 0; p < mic_pkg::NUM_EXT; p++) begin : gExt
			assign hwSet[mic_pkg::IDX_EXT0 + p] = primed_r && edgeHit(
				edgeSelectReg_r[p*mic_pkg::EDGE_W +: mic_pkg::EDGE_W],
				pinPrev_r[p], extIrqPins[p]); // R7
		end
		for (genvar g = 0; g < mic_pkg::NUM_GRP; g++) begin : gGrp
			assign hwSet[mic_pkg::IDX_GRP0 + g] = |(srcSet & mic_pkg::GRP_MASK[g]); // R14
		end
	endgenerate

	assign hwSet[mic_pkg::IDX_CMP]   = primed_r && (cmpOut != cmpPrev_r); // R12
	assign hwSet[mic_pkg::IDX_CONV]  = convDone; // R17
	assign hwSet[mic_pkg::IDX_TICK0] = tickEvt[0]; // R18
	assign hwSet[mic_pkg::IDX_TICK1] = tickEvt[1]; // R18
	assign srcSet = {eepromEvt, lowVoltEvt, timerEvt};

	mic_time_base #(.CNT_W(mic_pkg::TB_CNT_W)) uTick0 (
		.clk     (clk),
		.rst     (rst),
		.ctrl    (tick0Control_r),
		.subTick (subTick),
		.tick    (tickEvt[0])
	);

	mic_time_base #(.CNT_W(mic_pkg::TB_CNT_W)) uTick1 (
		.clk     (clk),
		.rst     (rst),
		.ctrl    (tick1Control_r),
		.subTick (subTick),
		.tick    (tickEvt[1])
	);

	// ==========================================================
	// flags: hardware set wins over software write and service clear
	always_comb begin
		reqFlags_nxt = reqFlags_r;
		if (wrEn && avs_address == mic_pkg::REG_FLAGS)
			reqFlags_nxt = (reqFlags_r & ~laneMask[9:0]) | (avs_writedata[9:0] & laneMask[9:0]);
		reqFlags_nxt = (reqFlags_nxt & ~ackClr) | hwSet; // R2 R10 R13 R15 R17 R18
	end

	// source flags are never cleared by service, only by software; hardware events set them
	always_comb begin
		srcFlags_nxt = srcFlags_r;
		if (wrEn && avs_address == mic_pkg::REG_SRCFLAG)
			srcFlags_nxt = (srcFlags_r & ~laneMask[9:0]) | (avs_writedata[9:0] & laneMask[9:0]);
		srcFlags_nxt = srcFlags_nxt | srcSet; // R16
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reqFlags_r <= '0;
			srcFlags_r <= '0;
		end else begin
			reqFlags_r <= reqFlags_nxt;
			srcFlags_r <= srcFlags_nxt;
		end
	end

	// ==========================================================
	// arbitration and call sequencing
	assign pending    = reqFlags_r & irqEnable_r & {mic_pkg::NUM_IRQ{globalIrqEnable_r}}; // R8
	assign irqPending = |pending;
	assign ackTake    = irqPending && !stackFull && cpuReady; // R4
	assign ackIdx     = lowestOne(pending); // R5
	assign ackClr     = ackTake ? (mic_pkg::NUM_IRQ'(1) << ackIdx) : '0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			call      <= '0;
			lastIdx_r <= '0;
		end else begin
			call.push <= ackTake; // R23
			if (ackTake) begin
				call.pushData  <= pcIn;
				call.fetchAddr <= mic_pkg::VEC_BASE + mic_pkg::VEC_STEP * 12'(ackIdx);
				lastIdx_r      <= ackIdx;
			end
		end
	end

	// enables play no part in wake-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wakeUp <= 1'b0;
		else
			wakeUp <= |(hwSet & ~reqFlags_r); // R6
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	gie_clear_a: assert property (ackTake |=> !globalIrqEnable_r) // R1
		else $error("global enable not cleared after acknowledge");
	pend_keep_a: assert property (|hwSet && !globalIrqEnable_r |=>
		(reqFlags_r & $past(hwSet)) == $past(hwSet)) // R2
		else $error("request lost while global enable clear");
	stack_hold_a: assert property (stackFull |=> !call.push) // R4
		else $error("acknowledge while stack full");
	prio_order_a: assert property (ackTake |->
		((pending & ((mic_pkg::NUM_IRQ'(1) << ackIdx) - mic_pkg::NUM_IRQ'(1))) == '0)) // R5
		else $error("higher priority request skipped");
	wake_rise_a: assert property (|(hwSet & ~reqFlags_r) |=> wakeUp) // R6
		else $error("flag rose without wake-up");
	ext_edge_a: assert property (primed_r && edgeSelectReg_r[1:0] == mic_pkg::EDGE_RISE &&
		!pinPrev_r[0] && extIrqPins[0] |=> reqFlags_r[mic_pkg::IDX_EXT0]) // R7
		else $error("rising edge did not set pin flag");
	ext_gate_a: assert property (ackTake |-> irqEnable_r[ackIdx] && globalIrqEnable_r) // R8
		else $error("vector taken without enables");
	svc_clear_a: assert property (ackTake && !hwSet[ackIdx] |=>
		!reqFlags_r[$past(ackIdx)]) // R10
		else $error("serviced flag not cleared");
	cmp_change_a: assert property (primed_r && cmpOut != cmpPrev_r |=>
		reqFlags_r[mic_pkg::IDX_CMP]) // R12
		else $error("comparator change missed");
	src_keep_a: assert property (ackTake && !wrEn |=>
		(srcFlags_r & $past(srcFlags_r)) == $past(srcFlags_r)) // R16
		else $error("source flags cleared by service");
	call_vec_a: assert property (ackTake |=> call.push &&
		call.fetchAddr == mic_pkg::VEC_BASE + mic_pkg::VEC_STEP * 12'($past(ackIdx)) &&
		call.pushData == $past(pcIn)) // R23
		else $error("vector or pushed counter wrong");
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer later than one wait state");

	ack_ext_c: cover property (ackTake && ackIdx == mic_pkg::IDX_W'(mic_pkg::IDX_EXT0));
	ack_grp_c: cover property (ackTake && ackIdx == mic_pkg::IDX_W'(mic_pkg::IDX_GRP0));
	stall_c:   cover property (irqPending && stackFull ##1 ackTake);
	tick_c:    cover property (tickEvt[0] ##[1:4] call.push);
endmodule // mic_intc

// file: verif/mic_cpu_model.sv
// cpu core stand-in: return stack, running program counter, call bookkeeping
`timescale 1ns/10ps
module mic_cpu_model #(
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// call interface
	input  wire mic_pkg::mic_call_s call,
	output logic                    cpuReady,
	output logic                    stackFull,
	output logic [11:0]             pcIn,
	// bench hooks
	input  wire logic               doRet,
	output int                      pushes,
	output logic [11:0]             wantPc
);
	// ==========================================================
	// return stack
	int          depth_r;
	logic [11:0] prevPc_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			depth_r <= 0;
			pushes  <= 0;
		end else begin
			depth_r <= depth_r + int'(call.push) - int'(doRet && depth_r > 0);
			pushes  <= pushes + int'(call.push);
		end
	end

	// full only at the top level; a return frees one level
	assign stackFull = (depth_r >= DEPTH);

	// ==========================================================
	// program counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pcIn     <= 12'h100;
			prevPc_r <= 12'h000;
			wantPc   <= 12'h000;
		end else begin
			pcIn     <= pcIn + 12'h001;
			prevPc_r <= pcIn;
			if (call.push) begin
				wantPc <= prevPc_r;
			end
		end
	end

	// multi-cycle instructions: one cycle in four is not a boundary
	assign cpuReady = (pcIn[1:0] != 2'h3);
endmodule // mic_cpu_model

// file: verif/mic_intc_tb.sv
// self-checking bench for the interrupt controller: bus, events, calls, time bases
`timescale 1ns/10ps
module mic_intc_tb;
	// ==========================================================
	// signals
	logic               clk            = 1'b0;
	logic               rst            = 1'b1;
	logic [4:0]         avs_address    = 5'h00;
	logic               avs_read       = 1'b0;
	logic               avs_write      = 1'b0;
	logic [31:0]        avs_writedata  = 32'h0;
	logic [3:0]         avs_byteenable = 4'hf;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	logic [2:0]         extIrqPins     = 3'h0;
	logic               cmpOut         = 1'b0;
	logic               convDone       = 1'b0;
	logic [7:0]         timerEvt       = 8'h00;
	logic               lowVoltEvt     = 1'b0;
	logic               eepromEvt      = 1'b0;
	logic               subTick        = 1'b0;
	logic               cpuReady;
	logic               stackFull;
	logic [11:0]        pcIn;
	mic_pkg::mic_call_s call;
	logic               irqPending;
	logic               wakeUp;
	logic               doRet          = 1'b0;
	logic [11:0]        wantPc;
	logic [1:0]         subDiv_r       = 2'h0;
	logic [31:0]        q;
	int                 pushes;
	int                 wakeCnt        = 0;
	int                 cyc            = 0;
	int                 lastWake       = 0;
	int                 mismatches     = 0;
	int                 comparisons    = 0;

	mic_intc uut (
		.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .extIrqPins, .cmpOut, .convDone, .timerEvt,
		.lowVoltEvt, .eepromEvt, .subTick, .cpuReady, .stackFull, .pcIn, .call,
		.irqPending, .wakeUp
	);

	mic_cpu_model #(.DEPTH(2)) cpu (
		.clk, .rst, .call, .cpuReady, .stackFull, .pcIn, .doRet, .pushes, .wantPc
	);

	initial forever #4 clk = ~clk;

	// sub clock enable every third system clock
	always @(posedge clk) begin
		subDiv_r <= (subDiv_r == 2'h2) ? 2'h0 : subDiv_r + 2'h1;
		subTick  <= (subDiv_r == 2'h2);
	end

	always @(posedge clk) begin
		cyc++;
		if (wakeUp === 1'b1) begin
			wakeCnt++;
			lastWake = cyc;
		end
	end

	// ==========================================================
	// tasks
	task automatic test_done();
		if (mismatches == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic fail(input string m);
		mismatches++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fail($sformatf("%s got %h expected %h", m, got, exp));
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (n >= 40) begin
			fail("bus hang");
			test_done();
		end
		@(posedge clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e, $sformatf("read %h", a));
	endtask

	task automatic wait_more(input logic onWake, input int lim);
		int n0;
		int n;
		n0 = onWake ? wakeCnt : pushes;
		n  = 0;
		while ((onWake ? wakeCnt : pushes) == n0 && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			fail("wait ran out");
			test_done();
		end
	endtask

	task automatic ret();
		doRet <= 1'b1;
		tick(1);
		doRet <= 1'b0;
		tick(1);
	endtask

	task automatic serve(input int idx);
		wr(mic_pkg::REG_ENABLE, 32'h7ff);
		wait_more(1'b0, 50);
		chk(32'(call.fetchAddr), 32'(mic_pkg::VEC_BASE + mic_pkg::VEC_STEP * idx), "vector");
		chk(32'(call.pushData), 32'(wantPc), "pushed pc");
	endtask

	// interval between two overflows, flag cleared in between
	task automatic tb_measure(input logic [4:0] a, input logic [31:0] ctl, input logic [31:0] e);
		int t1;
		wr(a, ctl);
		wait_more(1'b1, 70000);
		t1 = lastWake;
		wr(mic_pkg::REG_FLAGS, 32'h0);
		wait_more(1'b1, 70000);
		chk(32'(lastWake - t1), e, "tick period");
		wr(a, 32'h0);
		wr(mic_pkg::REG_FLAGS, 32'h0);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		tick(16);
		rst <= 1'b0;
		tick(1);
		for (int a = 0; a < 32; a += 4) begin
			rdc(5'(a), 32'h0);
		end
		wr(mic_pkg::REG_ENABLE, 32'h7fe);
		rdc(mic_pkg::REG_ENABLE, 32'h7fe);
		// one byte lane only: enables 7..9 live in byte 1
		avs_byteenable <= 4'h2;
		wr(mic_pkg::REG_ENABLE, 32'h0);
		rdc(mic_pkg::REG_ENABLE, 32'h0fe);
		avs_byteenable <= 4'hf;
		wr(mic_pkg::REG_ENABLE, 32'h7fe);
		for (int m = 0; m < 4; m++) begin
			wr(mic_pkg::REG_EDGE, {26'h0, 2'(m), 2'(m), 2'(m)});
			extIrqPins <= 3'h7;
			tick(2);
			rdc(mic_pkg::REG_FLAGS, m[0] ? 32'h7 : 32'h0);
			wr(mic_pkg::REG_FLAGS, 32'h0);
			extIrqPins <= 3'h0;
			tick(2);
			rdc(mic_pkg::REG_FLAGS, m[1] ? 32'h7 : 32'h0);
			wr(mic_pkg::REG_FLAGS, 32'h0);
		end
		chk(32'(wakeCnt), 32'h4, "wake count");
		cmpOut <= 1'b1;
		tick(2);
		rdc(mic_pkg::REG_FLAGS, 32'h8);
		wr(mic_pkg::REG_FLAGS, 32'h0);
		cmpOut <= 1'b0;
		tick(2);
		rdc(mic_pkg::REG_FLAGS, 32'h8);
		timerEvt   <= 8'h11;
		lowVoltEvt <= 1'b1;
		eepromEvt  <= 1'b1;
		convDone   <= 1'b1;
		tick(1);
		timerEvt   <= 8'h00;
		lowVoltEvt <= 1'b0;
		eepromEvt  <= 1'b0;
		convDone   <= 1'b0;
		tick(2);
		rdc(mic_pkg::REG_FLAGS, 32'hf8);
		rdc(mic_pkg::REG_SRCFLAG, 32'h311);
		chk(32'(wakeCnt), 32'h7, "wake count");
		// preset flags hide the next edges from the wake logic
		wr(mic_pkg::REG_FLAGS, 32'hf9);
		extIrqPins <= 3'h1;
		convDone   <= 1'b1;
		tick(1);
		convDone   <= 1'b0;
		tick(3);
		chk(32'(wakeCnt), 32'h7, "wake suppressed");
		rdc(mic_pkg::REG_STATUS, 32'h0);
		chk(32'(pushes), 32'h0, "no call while disabled");
		wr(mic_pkg::REG_FLAGS, 32'h3ff);
		for (int i = 0; i < 10; i++) begin
			serve(i);
			rdc(mic_pkg::REG_FLAGS, (32'h3ff << (i + 1)) & 32'h3ff);
			rdc(mic_pkg::REG_STATUS, 32'(i) << 4);
			chk(32'(pushes), 32'(i + 1), "single call");
			ret();
		end
		rdc(mic_pkg::REG_SRCFLAG, 32'h311);
		wr(mic_pkg::REG_SRCFLAG, 32'h0);
		rdc(mic_pkg::REG_SRCFLAG, 32'h0);
		// two nested calls fill the stack; the third waits for a return
		wr(mic_pkg::REG_FLAGS, 32'h380);
		serve(7);
		serve(8);
		wr(mic_pkg::REG_ENABLE, 32'h7ff);
		tick(20);
		rdc(mic_pkg::REG_STATUS, 32'h87);
		chk(32'(irqPending), 32'h1, "pending while full");
		chk(32'(pushes), 32'hc, "held while full");
		ret();
		wait_more(1'b0, 50);
		chk(32'(call.fetchAddr), 32'h28, "vector after return");
		ret();
		ret();
		tb_measure(mic_pkg::REG_TB0, 32'h080, 32'h100);
		tb_measure(mic_pkg::REG_TB0, 32'h081, 32'h200);
		tb_measure(mic_pkg::REG_TB0, 32'h180, 32'h400);
		tb_measure(mic_pkg::REG_TB0, 32'h280, 32'h300);
		tb_measure(mic_pkg::REG_TB1, 32'h380, 32'h300);
		tb_measure(mic_pkg::REG_TB1, 32'h087, 32'h8000);
		test_done();
	end
endmodule // mic_intc_tb
